//--- logic/acsc_pkg.sv
// Package of register map, field layout and timing constants for audio clock status/control
package acsc_pkg;

    localparam int          ADDR_W          = 12;
    localparam logic [11:0] OFF_CLK_STATUS  = 12'h000;
    localparam logic [11:0] OFF_DEV_ID      = 12'h004;
    localparam logic [11:0] OFF_ERR_FLAGS   = 12'h008;
    localparam logic [11:0] OFF_SYS_CTL1    = 12'h00C;
    localparam logic [11:0] OFF_SER_FMT     = 12'h010;
    localparam logic [11:0] OFF_SYS_CTL2    = 12'h014;
    localparam logic [11:0] OFF_SOFT_MUTE   = 12'h018;
    localparam logic [11:0] OFF_MUTE_STATUS = 12'h01C;

    localparam logic [7:0] RST_SYS_CTL1 = 8'hA0;
    localparam logic [3:0] RST_SER_FMT  = 4'h5;
    localparam logic [7:0] RST_SYS_CTL2 = 8'h40;
    localparam logic [1:0] RST_SOFT_MUTE = 2'h0;

    localparam int BIT_ERR_MCLK  = 7;
    localparam int BIT_ERR_PLL   = 6;
    localparam int BIT_ERR_SCLK  = 5;
    localparam int BIT_ERR_LRCLK = 4;
    localparam int BIT_ERR_SLIP  = 3;
    localparam int BIT_ERR_OVC   = 1;
    localparam logic [7:0] ERR_MASK = 8'hFA;

    localparam int BIT_DC_BLOCK  = 7;
    localparam int BIT_HARD_UNMUTE = 5;
    localparam int BIT_SHUTDOWN  = 6;

    // Sample-rate codes
    localparam logic [2:0] FS_32K  = 3'h0;
    localparam logic [2:0] FS_48K  = 3'h3;
    localparam logic [2:0] FS_16K  = 3'h4;
    localparam logic [2:0] FS_24K  = 3'h5;
    localparam logic [2:0] FS_8K   = 3'h6;
    localparam logic [2:0] FS_12K  = 3'h7;
    // Master-clock ratio codes
    localparam logic [2:0] MR_64   = 3'h0;
    localparam logic [2:0] MR_128  = 3'h1;
    localparam logic [2:0] MR_192  = 3'h2;
    localparam logic [2:0] MR_256  = 3'h3;
    localparam logic [2:0] MR_384  = 3'h4;
    localparam logic [2:0] MR_512  = 3'h5;
    localparam logic [2:0] MR_BAD  = 3'h7;

    localparam logic [1:0] DEEMPH_NONE = 2'h0;
    localparam logic [3:0] FMT_LAST    = 4'h8;

    // Ramp step times in ns and cycle counts at 100 MHz
    localparam int CLK_NS         = 10;
    localparam int STEP_8K_NS     = 125000;
    localparam int STEP_11K_NS    = 90700;
    localparam int STEP_12K_NS    = 83300;
    localparam int STEP_8K_CYC    = STEP_8K_NS / CLK_NS;
    localparam int STEP_11K_CYC   = STEP_11K_NS / CLK_NS;
    localparam int STEP_12K_CYC   = STEP_12K_NS / CLK_NS;
    localparam int RAMP_STEPS     = 1024;

endpackage

//--- logic/acsc_regs.sv
// Clock status, error flags and control registers of the stereo audio amplifier
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - see: rates auto-detected, read-only status register
// - see: sample-rate code in bits 7..5
// - see: master-clock ratio code in bits 4..2
// - see: unsupported ratio/rate pairs flagged invalid
// - see: ID register, fixed low seven bits
// - see: sticky error flags, cleared by writing zero
// - see: error bit map, zero when clean
// - see: master clocks per frame varies, error
// - see: bit clocks per frame varies, error
// - see: frame clock frequency changes, error
// - see: frame phase drifts from internal sync
// - see: bit 7 enables dc-blocking filter
// - see: bit 5 selects hard or soft unmute
// - see: bits 1..0 select de-emphasis
// - see: nine serial formats, default I2S 24
// - see: shutdown bit holds hard mute
// - see: per-channel soft mute bits
// - see: volume ramp step time by rate
module acsc_regs
    import acsc_pkg::*;
#(
    parameter logic [6:0] ID_CODE   = 7'h2A,   // Arbitrary revision code
    parameter int         SYNC_DIV  = 2048,    // Internal frame sync period in mclks
    parameter int         STEP_8K   = acsc_pkg::STEP_8K_CYC,
    parameter int         STEP_11K  = acsc_pkg::STEP_11K_CYC,
    parameter int         STEP_12K  = acsc_pkg::STEP_12K_CYC,
    parameter int         RAMP_LEN  = acsc_pkg::RAMP_STEPS
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [acsc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      mclk_tick,
    input  wire logic                      sclk_tick,
    input  wire logic                      lrclk_in,
    input  wire logic                      pll_unlock,
    input  wire logic                      over_current,
    output logic                           dc_block_en,
    output logic [1:0]                     deemph_sel,
    output logic [3:0]                     serial_format,
    output logic                           shutdown,
    output logic [1:0]                     ch_soft_mute,
    output logic                           clock_mute,
    output logic                           ramp_step
);
    import acsc_pkg::*;

    // ****************************************
    // Bus decode
    // ****************************************
    logic        acc;
    logic        wr;
    logic        hit;
    assign acc = psel & penable;
    assign wr  = acc & pwrite & pstrb[0];
    always_comb begin
        case (paddr)
            OFF_CLK_STATUS, OFF_DEV_ID, OFF_ERR_FLAGS, OFF_SYS_CTL1,
            OFF_SER_FMT, OFF_SYS_CTL2, OFF_SOFT_MUTE, OFF_MUTE_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // ****************************************
    // Clock measurement
    // ****************************************
    logic        lr_q, lr_d;
    logic [15:0] mcnt_q, mcnt_d, mlast_q, mlast_d;
    logic [7:0]  scnt_q, scnt_d, slast_q, slast_d;
    logic [15:0] sync_q, sync_d;
    logic [15:0] slip_ref_q, slip_ref_d;
    logic        meas_ok_q, meas_ok_d;
    logic        ev_mclk, ev_sclk, ev_lr, ev_slip;
    logic [2:0]  fs_q, fs_d, ratio_q, ratio_d;
    logic        frame_edge;

    assign frame_edge = lrclk_in & ~lr_q;

    // Ratio code from master clocks per frame; invalid pairs map to reserved
    function automatic logic [2:0] ratio_code(input logic [15:0] n, input logic [2:0] fs);
        logic [2:0] r;
        case (n)
            16'd64:  r = MR_64;
            16'd128: r = MR_128;
            16'd192: r = MR_192;
            16'd256: r = MR_256;
            16'd384: r = MR_384;
            16'd512: r = MR_512;
            default: r = MR_BAD;
        endcase
        if (r == MR_64 && fs != FS_48K)
            r = MR_BAD;
        if (r == MR_192 && fs != FS_48K && fs != FS_32K)
            r = MR_BAD;
        if (r == MR_256 && fs == FS_8K)
            r = MR_BAD;
        return r;
    endfunction

    // Rate class from frame length in pclk cycles (100 MHz)
    function automatic logic [2:0] fs_code(input logic [15:0] p);
        logic [2:0] f;
        if (p < 16'd2500)       f = FS_48K;
        else if (p < 16'd3600)  f = FS_32K;
        else if (p < 16'd5000)  f = FS_24K;
        else if (p < 16'd7200)  f = FS_16K;
        else if (p < 16'd10000) f = FS_12K;
        else                    f = FS_8K;
        return f;
    endfunction

    logic [15:0] per_q, per_d, plast_q, plast_d;

    always_comb begin
        lr_d       = lrclk_in;
        mcnt_d     = mcnt_q + {15'd0, mclk_tick};
        scnt_d     = scnt_q + {7'd0, sclk_tick};
        per_d      = per_q + 16'd1;
        mlast_d    = mlast_q;
        slast_d    = slast_q;
        plast_d    = plast_q;
        meas_ok_d  = meas_ok_q;
        fs_d       = fs_q;
        ratio_d    = ratio_q;
        // Advance only on a master clock, so a steady multiple of SYNC_DIV mclks per frame keeps the same phase
        sync_d     = !mclk_tick ? sync_q
                   : (sync_q == 16'(SYNC_DIV - 1)) ? 16'd0 : sync_q + 16'd1;
        slip_ref_d = slip_ref_q;
        ev_mclk    = 1'b0;
        ev_sclk    = 1'b0;
        ev_lr      = 1'b0;
        ev_slip    = 1'b0;
        if (frame_edge) begin
            // Tick of the edge cycle opens the new count, else one is lost per frame
            mcnt_d    = {15'd0, mclk_tick};
            scnt_d    = {7'd0, sclk_tick};
            per_d     = 16'd0;
            mlast_d   = mcnt_q;
            slast_d   = scnt_q;
            plast_d   = per_q;
            meas_ok_d = 1'b1;
            slip_ref_d = sync_q;
            if (meas_ok_q) begin
                ev_mclk = (mcnt_q != mlast_q);
                ev_sclk = (scnt_q != slast_q);
                ev_lr   = (per_q > plast_q + 16'd2) || (plast_q > per_q + 16'd2);
                ev_slip = (sync_q != slip_ref_q) && !ev_mclk;
            end
            fs_d    = fs_code(per_q);
            ratio_d = ratio_code(mcnt_q, fs_code(per_q));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lr_q       <= 1'b0;
            mcnt_q     <= 16'd0;
            scnt_q     <= 8'd0;
            per_q      <= 16'd0;
            mlast_q    <= 16'd0;
            slast_q    <= 8'd0;
            plast_q    <= 16'd0;
            meas_ok_q  <= 1'b0;
            fs_q       <= FS_48K;
            ratio_q    <= MR_256;
            sync_q     <= 16'd0;
            slip_ref_q <= 16'd0;
        end else begin
            lr_q       <= lr_d;
            mcnt_q     <= mcnt_d;
            scnt_q     <= scnt_d;
            per_q      <= per_d;
            mlast_q    <= mlast_d;
            slast_q    <= slast_d;
            plast_q    <= plast_d;
            meas_ok_q  <= meas_ok_d;
            fs_q       <= fs_d;
            ratio_q    <= ratio_d;
            sync_q     <= sync_d;
            slip_ref_q <= slip_ref_d;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] err_q, err_d, ev_vec;
    logic [7:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d;
    logic [3:0] fmt_q, fmt_d;
    logic [1:0] smute_q, smute_d;

    always_comb begin
        ev_vec = 8'd0;
        ev_vec[BIT_ERR_MCLK]  = ev_mclk;
        ev_vec[BIT_ERR_PLL]   = pll_unlock;
        ev_vec[BIT_ERR_SCLK]  = ev_sclk;
        ev_vec[BIT_ERR_LRCLK] = ev_lr;
        ev_vec[BIT_ERR_SLIP]  = ev_slip;
        ev_vec[BIT_ERR_OVC]   = over_current;
        err_d   = err_q;
        ctl1_d  = ctl1_q;
        ctl2_d  = ctl2_q;
        fmt_d   = fmt_q;
        smute_d = smute_q;
        if (wr) begin
            case (paddr)
                OFF_ERR_FLAGS: err_d = err_q & pwdata[7:0];
                OFF_SYS_CTL1:  ctl1_d = pwdata[7:0] & 8'hA3;
                OFF_SER_FMT:   fmt_d = pwdata[3:0];
                OFF_SYS_CTL2:  ctl2_d = pwdata[7:0] & 8'h40;
                OFF_SOFT_MUTE: smute_d = pwdata[1:0];
                default: ;
            endcase
        end
        // Set beats a simultaneous clear
        err_d = (err_d | ev_vec) & ERR_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q   <= 8'd0;
            ctl1_q  <= RST_SYS_CTL1;
            ctl2_q  <= RST_SYS_CTL2;
            fmt_q   <= RST_SER_FMT;
            smute_q <= RST_SOFT_MUTE;
        end else begin
            err_q   <= err_d;
            ctl1_q  <= ctl1_d;
            ctl2_q  <= ctl2_d;
            fmt_q   <= fmt_d;
            smute_q <= smute_d;
        end
    end

    // ****************************************
    // Clock-error mute and unmute ramp
    // ****************************************
    typedef enum logic [1:0] {MS_RUN, MS_MUTED, MS_RAMP} acsc_mst_t;
    acsc_mst_t   mst_q, mst_d;
    logic [16:0] tick_q, tick_d;
    logic [11:0] steps_q, steps_d;
    logic        cmute_q, cmute_d, step_q, step_d;
    logic        clk_bad;
    logic [16:0] step_len;

    // Reserved formats are unusable, so they also count as a clock problem
    assign clk_bad = ev_mclk | ev_sclk | ev_lr | ev_slip | pll_unlock
                   | (ratio_q == MR_BAD) | (fmt_q > FMT_LAST);

    always_comb begin
        case (fs_q)
            FS_32K, FS_16K, FS_8K: step_len = 17'(STEP_8K);
            FS_12K, FS_24K:        step_len = 17'(STEP_12K);
            default:               step_len = 17'(STEP_11K);
        endcase
    end

    always_comb begin
        mst_d   = mst_q;
        tick_d  = tick_q;
        steps_d = steps_q;
        cmute_d = cmute_q;
        step_d  = 1'b0;
        case (mst_q)
            MS_RUN: begin
                if (clk_bad) begin
                    mst_d   = MS_MUTED;
                    cmute_d = 1'b1;
                end else begin
                    cmute_d = 1'b0;
                end
            end
            MS_MUTED: begin
                if (clk_bad) begin
                    cmute_d = 1'b1;
                end else if (frame_edge && meas_ok_q) begin
                    if (ctl1_q[BIT_HARD_UNMUTE]) begin
                        mst_d   = MS_RUN;
                        cmute_d = 1'b0;
                    end else begin
                        mst_d   = MS_RAMP;
                        tick_d  = 17'd0;
                        steps_d = 12'd0;
                    end
                end
            end
            MS_RAMP: begin
                if (clk_bad) begin
                    mst_d = MS_MUTED;
                end else if (tick_q >= step_len - 17'd1) begin
                    tick_d  = 17'd0;
                    step_d  = 1'b1;
                    steps_d = steps_q + 12'd1;
                    // Mute drops a cycle after the last step, so no step is seen unmuted
                    if (steps_q == 12'(RAMP_LEN - 1)) begin
                        mst_d   = MS_RUN;
                    end
                end else begin
                    tick_d = tick_q + 17'd1;
                end
            end
            default: mst_d = MS_MUTED;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mst_q   <= MS_MUTED;
            tick_q  <= 17'd0;
            steps_q <= 12'd0;
            cmute_q <= 1'b1;
            step_q  <= 1'b0;
        end else begin
            mst_q   <= mst_d;
            tick_q  <= tick_d;
            steps_q <= steps_d;
            cmute_q <= cmute_d;
            step_q  <= step_d;
        end
    end

    // ****************************************
    // Read path and outputs
    // ****************************************
    logic [31:0] rd_d;
    logic        err_resp_d;
    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            OFF_CLK_STATUS:  rd_d[7:0] = {fs_q, ratio_q, 2'b00};
            OFF_DEV_ID:      rd_d[7:0] = {1'b0, ID_CODE};
            OFF_ERR_FLAGS:   rd_d[7:0] = err_q;
            OFF_SYS_CTL1:    rd_d[7:0] = ctl1_q;
            OFF_SER_FMT:     rd_d[3:0] = fmt_q;
            OFF_SYS_CTL2:    rd_d[7:0] = ctl2_q;
            OFF_SOFT_MUTE:   rd_d[1:0] = smute_q;
            OFF_MUTE_STATUS: rd_d[2:0] = {mst_q == MS_RAMP, cmute_q, ctl2_q[BIT_SHUTDOWN]};
            default:         rd_d = 32'h0000_0000;
        endcase
        err_resp_d = psel & ~penable & ~hit;
    end

    // Zero-wait slave: answer registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata        <= 32'h0000_0000;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            dc_block_en   <= 1'b1;
            deemph_sel    <= DEEMPH_NONE;
            serial_format <= RST_SER_FMT;
            shutdown      <= 1'b1;
            ch_soft_mute  <= RST_SOFT_MUTE;
            clock_mute    <= 1'b1;
            ramp_step     <= 1'b0;
        end else begin
            prdata        <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0000_0000;
            pready        <= psel & ~penable;
            pslverr       <= err_resp_d;
            dc_block_en   <= ctl1_d[BIT_DC_BLOCK];
            deemph_sel    <= ctl1_d[1:0];
            serial_format <= fmt_d;
            shutdown      <= ctl2_d[BIT_SHUTDOWN];
            ch_soft_mute  <= smute_d;
            clock_mute    <= cmute_d;
            ramp_step     <= step_d;
        end
    end

    // Source keeps bit clock within 32/48/64 Fs; only a change in bit clocks per frame shows as an error
    // Host clears errors then rereads to see persistence
endmodule

`default_nettype wire

//--- dv/acsc_regs_monitor.sv
// Checker of bus timing, read data and control outputs of the register block
`timescale 1ns/1ns
`default_nettype none
module acsc_regs_chk
    import acsc_pkg::*;
#(
    parameter logic [6:0] ID_CODE = 7'h2A   // Arbitrary revision code
) (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [acsc_pkg::ADDR_W-1:0]  paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic [3:0]                   pstrb,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic                         pll_unlock,
    input wire logic                         dc_block_en,
    input wire logic [1:0]                   deemph_sel,
    input wire logic [3:0]                   serial_format,
    input wire logic                         shutdown,
    input wire logic [1:0]                   ch_soft_mute,
    input wire logic                         clock_mute,
    input wire logic                         ramp_step
);
    wire logic su = psel && !penable;
    wire logic sw = su && pwrite && pstrb[0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ack_after_setup:
        assert property (su |=> pready ##1 !pready) else $error("pready not one cycle");
    chk_unmapped_error:
        assert property (su && paddr > OFF_MUTE_STATUS |=> pslverr) else $error("no pslverr");
    chk_idle_data_zero:
        assert property (!pready |-> prdata == 32'h0000_0000) else $error("idle prdata");
    chk_id_readback:
        assert property (su && !pwrite && paddr == OFF_DEV_ID |=>
            prdata == {24'h00_0000, 1'b0, ID_CODE}) else $error("bad id");
    chk_error_set_read:
        assert property (su && !pwrite && paddr == OFF_ERR_FLAGS && $past(pll_unlock) |=>
            prdata[BIT_ERR_PLL]) else $error("pll flag not set");
    chk_shutdown_follow:
        assert property (sw && paddr == OFF_SYS_CTL2 |=>
            ##1 shutdown == $past(pwdata[BIT_SHUTDOWN], 2)) else $error("shutdown");
    chk_mute_follow:
        assert property (sw && paddr == OFF_SOFT_MUTE |=>
            ##1 ch_soft_mute == $past(pwdata[1:0], 2)) else $error("soft mute");
    chk_format_follow:
        assert property (sw && paddr == OFF_SER_FMT |=>
            ##1 serial_format == $past(pwdata[3:0], 2)) else $error("format");
    chk_ctl_one_follow:
        assert property (sw && paddr == OFF_SYS_CTL1 |=> ##1
            {dc_block_en, deemph_sel} == {$past(pwdata[7], 2), $past(pwdata[1:0], 2)})
            else $error("ctl1 outputs");
    chk_ramp_while_muted:
        assert property (ramp_step |-> clock_mute) else $error("ramp while unmuted");
endmodule

bind acsc_regs acsc_regs_chk #(.ID_CODE(ID_CODE)) u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .pll_unlock, .dc_block_en, .deemph_sel, .serial_format,
    .shutdown, .ch_soft_mute, .clock_mute, .ramp_step
);
`default_nettype wire

//--- dv/acsc_regs_tb_top.sv
// Self-checking bench of the audio clock status and control registers
`timescale 1ns/1ns
`default_nettype none
module acsc_regs_tb_top;
    import acsc_pkg::*;
    localparam logic [6:0] ID = 7'h15;   // Arbitrary revision code
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, serial_format;
    logic        mclk_tick, sclk_tick, lrclk_in, pll_unlock, over_current;
    logic        dc_block_en, shutdown, clock_mute, ramp_step;
    logic [1:0]  deemph_sel, ch_soft_mute;
    logic [33:0] exp_q[$];
    logic [15:0] lfsr;
    int          n_errors, tests_run, cyc, per, nm, ns, ph;

    // Short ramp counts keep the run brief
    acsc_regs #(.ID_CODE(ID), .SYNC_DIV(128), .STEP_8K(4), .STEP_11K(4), .STEP_12K(4),
        .RAMP_LEN(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .mclk_tick, .sclk_tick, .lrclk_in,
        .pll_unlock, .over_current, .dc_block_en, .deemph_sel, .serial_format,
        .shutdown, .ch_soft_mute, .clock_mute, .ramp_step);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // **********
    // Bus master
    // **********
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic k);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        exp_q.push_back({w, e});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        penable <= 1'b0;
        if (!k) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, {1'b0, e}, 1'b0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic k = 1'b0);
        apb(1'b1, a, d, 33'h0_0000_0000, k);
    endtask

    task automatic defaults;
        check({dc_block_en, deemph_sel, serial_format, shutdown, ch_soft_mute, clock_mute},
            {1'b1, DEEMPH_NONE, RST_SER_FMT, 1'b1, RST_SOFT_MUTE, 1'b1});
        rd(OFF_CLK_STATUS, {FS_48K, MR_256, 2'b00});
        rd(OFF_DEV_ID, ID);
        rd(OFF_ERR_FLAGS, 0);
        rd(OFF_SYS_CTL1, RST_SYS_CTL1);
        rd(OFF_SER_FMT, RST_SER_FMT);
        rd(OFF_SYS_CTL2, RST_SYS_CTL2);
        rd(OFF_SOFT_MUTE, RST_SOFT_MUTE);
    endtask

    task automatic unmute(output int pulses);
        int n;
        n = 0;
        pulses = 0;
        while (clock_mute !== 1'b0 && n < 30000) begin
            @(posedge pclk);
            n++;
            if (ramp_step === 1'b1) pulses++;
        end
    endtask

    // ***********************************
    // Outputs, frame source and time limit
    // ***********************************
    always @(posedge pclk) begin
        logic [33:0] e;
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            if (e[33]) check({pslverr, 32'h0}, {e[32], 32'h0});
            else check({pslverr, prdata}, e[32:0]);
        end
    end

    // Ticks sit at the start of each frame, so a count change lands whole
    always @(posedge pclk) begin
        ph <= (per == 0 || ph + 1 >= per) ? 0 : ph + 1;
        lrclk_in <= per != 0 && ph < per / 2;
        mclk_tick <= per != 0 && ph < nm;
        sclk_tick <= per != 0 && ph < ns;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            final_report();
        end
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  dm;
        int          p;
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        pstrb = 4'hF; mclk_tick = 0; sclk_tick = 0; lrclk_in = 0; pll_unlock = 0;
        over_current = 0; n_errors = 0; tests_run = 0; cyc = 0; ph = 0;
        per = 0; nm = 128; ns = 64; lfsr = 16'h0033;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        defaults();
        wr(OFF_CLK_STATUS, 32'h0000_00FF);
        rd(OFF_CLK_STATUS, {FS_48K, MR_256, 2'b00});
        apb(1'b1, 12'h020, 32'h0000_00FF, {1'b1, 32'h0}, 1'b1);
        apb(1'b0, 12'h020, 32'h0000_0000, {1'b1, 32'h0}, 1'b0);
        pstrb <= 4'h0;
        wr(OFF_SOFT_MUTE, 32'h0000_0003);
        pstrb <= 4'hF;
        rd(OFF_SOFT_MUTE, 0);
        for (int i = 0; i <= 8; i++) begin
            lfsr = nxt(lfsr);
            d = {lfsr, nxt(lfsr)};
            dm = (i % 3 == 0) ? 2'b00 : 2'(1 + i % 3);
            wr(OFF_SYS_CTL1, {d[31:2], dm}, 1'b1);
            wr(OFF_SER_FMT, {d[31:4], 4'(i)}, 1'b1);
            wr(OFF_SOFT_MUTE, d, 1'b1);
            wr(OFF_SYS_CTL2, d);
            @(posedge pclk);
            check({dc_block_en, deemph_sel, serial_format, shutdown, ch_soft_mute},
                {d[7], dm, 4'(i), d[6], d[1:0]});
            rd(OFF_SYS_CTL1, {d[7], 1'b0, d[5], 3'b000, dm});
            rd(OFF_SER_FMT, i);
            rd(OFF_SYS_CTL2, {d[6], 6'h00});
            rd(OFF_SOFT_MUTE, d[1:0]);
        end
        wr(OFF_SYS_CTL1, 32'h0000_0080);
        per <= 3000;
        unmute(p);
        check(p, 4);
        rd(OFF_CLK_STATUS, {FS_32K, MR_128, 2'b00});
        wr(OFF_ERR_FLAGS, 0);
        rd(OFF_ERR_FLAGS, 0);
        pll_unlock <= 1'b1;
        over_current <= 1'b1;
        @(posedge pclk);
        rd(OFF_ERR_FLAGS, 32'h0000_0042);
        pll_unlock <= 1'b0;
        over_current <= 1'b0;
        rd(OFF_ERR_FLAGS, 32'h0000_0042);
        wr(OFF_ERR_FLAGS, 32'h0000_00FD);
        rd(OFF_ERR_FLAGS, 32'h0000_0040);
        unmute(p);
        for (int m = 0; m < 2; m++) begin
            wr(OFF_SYS_CTL1, m ? 32'h0000_0020 : 32'h0000_0000);
            wr(OFF_ERR_FLAGS, 0);
            ns <= 32;
            repeat (10000) @(posedge pclk);
            ns <= 64;
            while (clock_mute !== 1'b1 && cyc < 89000) @(posedge pclk);
            check(clock_mute, 1);
            unmute(p);
            check({32'(p), clock_mute}, {32'(m ? 0 : 4), 1'b0});
            rd(OFF_ERR_FLAGS, 32'h0000_0020);
        end
        nm <= 64;
        repeat (12000) @(posedge pclk);
        rd(OFF_CLK_STATUS, {FS_32K, MR_BAD, 2'b00});
        check(clock_mute, 1);
        per <= 0;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        defaults();
        check(exp_q.size(), 0);
        final_report();
    end
endmodule
`default_nettype wire
